// ==== common/rfsc_consts.svh ====
// offsets, field positions, reset values and timing constants of the radio front-end/synth register bank
`ifndef RFSC_CONSTS_SVH
`define RFSC_CONSTS_SVH
// ----------------------------------------
// register addresses
// ----------------------------------------
`define RFSC_ADDR_TX_FRONT_END 6'h22
`define RFSC_ADDR_CHARGE_PUMP 6'h23
`define RFSC_ADDR_VCO_CURRENT 6'h24
`define RFSC_ADDR_VCO_COARSE 6'h25
`define RFSC_ADDR_SYNTH_CTRL 6'h26
`define RFSC_ADDR_VOL_A 6'h29
`define RFSC_ADDR_VOL_B 6'h2a
`define RFSC_ADDR_VOL_C 6'h2b
`define RFSC_ADDR_TEST_TWO 6'h2c
// ----------------------------------------
// reset values
// ----------------------------------------
`define RFSC_RST_TX_FRONT_END 8'h10
`define RFSC_RST_CHARGE_PUMP 8'ha9
`define RFSC_RST_VCO_CURRENT 8'h0a
`define RFSC_RST_VCO_COARSE 8'h20
`define RFSC_RST_SYNTH_CTRL 8'h0d
`define RFSC_RST_VOL_A 8'h59
`define RFSC_RST_VOL_B 8'h7f
`define RFSC_RST_VOL_C 8'h3f
`define RFSC_RST_TEST_TWO 8'h88
`define RFSC_TEST_TWO_RETAIN 8'h81
// ----------------------------------------
// writable-bit masks (unused bits read zero)
// ----------------------------------------
`define RFSC_MASK_TX_FRONT_END 8'h37
`define RFSC_MASK_VCO_CURRENT 8'h3f
`define RFSC_MASK_VCO_COARSE 8'h3f
`define RFSC_MASK_SYNTH_CTRL 8'h7f
`define RFSC_MASK_FULL 8'hff
// ----------------------------------------
// field positions
// ----------------------------------------
`define RFSC_AMP_IDX_MSB 2
`define RFSC_CP_EN_MSB 5
`define RFSC_CP_EN_LSB 4
`define RFSC_CP_RES_MSB 3
`define RFSC_VCO_HIGH_BIT 5
`define RFSC_VCO_CUR_MSB 4
`define RFSC_COARSE_MSB 5
`define RFSC_LO_CUR_MSB 5
`define RFSC_LO_CUR_LSB 4
`define RFSC_CAL_CFG_MSB 7
`define RFSC_CAL_CFG_LSB 6
`define RFSC_CTRL_MSB 6
// ----------------------------------------
// calibration stage lengths in cycles
// ----------------------------------------
`define RFSC_STAGE_CYCLES 5'h10
`endif

// ==== common/rfsc_pkg.sv ====
// types shared by the radio front-end/synth register bank
package rfsc_pkg;
  typedef enum logic [2:0] {
    RFSC_CAL_IDLE,
    RFSC_CAL_CHARGE_PUMP,
    RFSC_CAL_VCO_CURRENT,
    RFSC_CAL_COARSE,
    RFSC_CAL_DONE
  } rfsc_cal_state_t;
endpackage

// ==== rtl/rfsc_power_table.sv ====
// two-entry amplifier power table indexed by the level field
`timescale 1ns/100ps
module rfsc_power_table #(
  parameter int ENTRIES = 2
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic write_in,
  input wire logic [2:0] write_index_in,
  input wire logic [7:0] write_data_in,
  input wire logic [2:0] level_index_in,
  output logic [7:0] amp_setting_out
);
  logic [7:0] table_mem [ENTRIES];
  logic [7:0] next_table_mem [ENTRIES];
  logic [7:0] next_amp_setting;

  // ----------------------------------------
  // table write and lookup
  // ----------------------------------------
  // indices past the last entry fold onto the top entry rather than reading garbage
  function automatic int unsigned clamp_index(input logic [2:0] idx);
    clamp_index = (int'(idx) >= ENTRIES) ? ENTRIES - 1 : int'(idx);
  endfunction

  always_comb begin
    next_table_mem = table_mem;
    if (write_in) begin
      next_table_mem[clamp_index(write_index_in)] = write_data_in;
    end
    next_amp_setting = table_mem[clamp_index(level_index_in)];
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int i = 0; i < ENTRIES; i++) begin
        table_mem[i] <= 8'h00;
      end
      amp_setting_out <= 8'h00;
    end else begin
      table_mem <= next_table_mem;
      amp_setting_out <= next_amp_setting;
    end
  end
endmodule

// ==== rtl/rfsc_regs.sv ====
// front-end and synthesizer calibration register bank with sleep-volatile test registers
`timescale 1ns/100ps
`include "rfsc_consts.svh"
module rfsc_regs
  import rfsc_pkg::*;
#(
  parameter int TABLE_ENTRIES = 2
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  input wire logic [5:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic table_write_in,
  input wire logic [2:0] table_index_in,
  input wire logic [7:0] table_data_in,
  input wire logic sleep_in,
  input wire logic converter_retention_select_in,
  input wire logic cal_start_in,
  input wire logic [3:0] cp_result_in,
  input wire logic [4:0] vco_current_result_in,
  input wire logic [5:0] coarse_result_in,
  output logic [7:0] reg_rdata_out,
  output logic [7:0] amp_setting_out,
  output logic [1:0] tx_lo_buffer_current_out,
  output logic vco_core_high_select_out,
  output logic [3:0] charge_pump_current_out,
  output logic [4:0] vco_current_out,
  output logic [5:0] vco_coarse_out,
  output logic [6:0] synth_cal_control_out,
  output logic [1:0] synth_cal_config_out,
  output logic [7:0] analog_test_word_out,
  output logic cal_busy_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  logic [7:0] tx_front_end_cfg, next_tx_front_end_cfg;
  logic [7:0] charge_pump_cal_reg, next_charge_pump_cal_reg;
  logic [7:0] vco_current_cal_reg, next_vco_current_cal_reg;
  logic [7:0] vco_coarse_cap_reg, next_vco_coarse_cap_reg;
  logic [7:0] synth_cal_control_reg, next_synth_cal_control_reg;
  logic [7:0] vol_a, next_vol_a;
  logic [7:0] vol_b, next_vol_b;
  logic [7:0] vol_c, next_vol_c;
  logic [7:0] test_two, next_test_two;
  logic [7:0] test_two_internal, next_test_two_internal;
  logic [7:0] next_rdata;
  logic sleep_meta, sleep_sync, sleep_prev;
  logic retain_meta, retain_sync;
  logic wake_event;
  rfsc_cal_state_t cal_state, next_cal_state;
  logic [4:0] stage_count, next_stage_count;

  // write strobe that hits one address
  function automatic logic hit(input logic [5:0] addr, input logic [5:0] target);
    hit = reg_write_in && (addr == target);
  endfunction

  // merge write data under a mask so unused bits stay zero
  function automatic logic [7:0] masked(input logic [7:0] data, input logic [7:0] mask);
    masked = data & mask;
  endfunction

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // sleep and retention come from the analog/power side, another domain
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      sleep_meta <= 1'b0;
      sleep_sync <= 1'b0;
      sleep_prev <= 1'b0;
      retain_meta <= 1'b0;
      retain_sync <= 1'b0;
    end else begin
      sleep_meta <= sleep_in;
      sleep_sync <= sleep_meta;
      sleep_prev <= sleep_sync;
      retain_meta <= converter_retention_select_in;
      retain_sync <= retain_meta;
    end
  end

  assign wake_event = sleep_prev && !sleep_sync;

  // ----------------------------------------
  // calibration sequencer
  // ----------------------------------------
  // a fixed-length stage per step; results are captured on stage exit
  always_comb begin
    next_cal_state = cal_state;
    next_stage_count = stage_count;
    unique case (cal_state)
      RFSC_CAL_IDLE: begin
        if (cal_start_in && !sleep_sync) begin
          next_stage_count = 5'h00;
          if (charge_pump_cal_reg[`RFSC_CP_EN_MSB:`RFSC_CP_EN_LSB] == 2'b00) begin
            next_cal_state = RFSC_CAL_VCO_CURRENT;
          end else begin
            next_cal_state = RFSC_CAL_CHARGE_PUMP;
          end
        end
      end
      RFSC_CAL_CHARGE_PUMP, RFSC_CAL_VCO_CURRENT, RFSC_CAL_COARSE: begin
        next_stage_count = stage_count + 5'h01;
        if (stage_count == `RFSC_STAGE_CYCLES - 5'h01) begin
          next_stage_count = 5'h00;
          next_cal_state = (cal_state == RFSC_CAL_CHARGE_PUMP) ? RFSC_CAL_VCO_CURRENT :
                           (cal_state == RFSC_CAL_VCO_CURRENT) ? RFSC_CAL_COARSE : RFSC_CAL_DONE;
        end
      end
      RFSC_CAL_DONE: begin
        next_cal_state = RFSC_CAL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cal_state <= RFSC_CAL_IDLE;
      stage_count <= 5'h00;
    end else begin
      cal_state <= next_cal_state;
      stage_count <= next_stage_count;
    end
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  // host writes win over a result capture in the same cycle, so an override sticks
  always_comb begin
    logic stage_end;
    stage_end = (stage_count == `RFSC_STAGE_CYCLES - 5'h01);
    next_tx_front_end_cfg = tx_front_end_cfg;
    next_charge_pump_cal_reg = charge_pump_cal_reg;
    next_vco_current_cal_reg = vco_current_cal_reg;
    next_vco_coarse_cap_reg = vco_coarse_cap_reg;
    next_synth_cal_control_reg = synth_cal_control_reg;
    next_vol_a = vol_a;
    next_vol_b = vol_b;
    next_vol_c = vol_c;
    next_test_two = test_two;
    next_test_two_internal = test_two_internal;
    // calibration results
    if (cal_state == RFSC_CAL_CHARGE_PUMP && stage_end) begin
      next_charge_pump_cal_reg[`RFSC_CP_RES_MSB:0] = cp_result_in;
    end
    if (cal_state == RFSC_CAL_VCO_CURRENT && stage_end) begin
      next_vco_current_cal_reg[`RFSC_VCO_CUR_MSB:0] = vco_current_result_in;
    end
    if (cal_state == RFSC_CAL_COARSE && stage_end) begin
      next_vco_coarse_cap_reg[`RFSC_COARSE_MSB:0] = coarse_result_in;
    end
    // host writes
    if (hit(reg_addr_in, `RFSC_ADDR_TX_FRONT_END)) begin
      next_tx_front_end_cfg = masked(reg_wdata_in, `RFSC_MASK_TX_FRONT_END);
    end
    if (hit(reg_addr_in, `RFSC_ADDR_CHARGE_PUMP)) begin
      next_charge_pump_cal_reg = reg_wdata_in;
    end
    if (hit(reg_addr_in, `RFSC_ADDR_VCO_CURRENT)) begin
      next_vco_current_cal_reg = masked(reg_wdata_in, `RFSC_MASK_VCO_CURRENT);
    end
    if (hit(reg_addr_in, `RFSC_ADDR_VCO_COARSE)) begin
      next_vco_coarse_cap_reg = masked(reg_wdata_in, `RFSC_MASK_VCO_COARSE);
    end
    if (hit(reg_addr_in, `RFSC_ADDR_SYNTH_CTRL)) begin
      next_synth_cal_control_reg = masked(reg_wdata_in, `RFSC_MASK_SYNTH_CTRL);
    end
    if (hit(reg_addr_in, `RFSC_ADDR_VOL_A)) begin
      next_vol_a = reg_wdata_in;
    end
    if (hit(reg_addr_in, `RFSC_ADDR_VOL_B)) begin
      next_vol_b = reg_wdata_in;
    end
    if (hit(reg_addr_in, `RFSC_ADDR_VOL_C)) begin
      next_vol_c = reg_wdata_in;
    end
    if (hit(reg_addr_in, `RFSC_ADDR_TEST_TWO)) begin
      next_test_two = reg_wdata_in;
      next_test_two_internal = reg_wdata_in;
    end
    // sleep loses the volatile group; wake restores defaults, internal test word RFSC_TEST_TWO_RETAIN if retention selected
    if (sleep_sync || wake_event) begin
      next_vol_a = `RFSC_RST_VOL_A;
      next_vol_b = `RFSC_RST_VOL_B;
      next_vol_c = `RFSC_RST_VOL_C;
      next_test_two = `RFSC_RST_TEST_TWO;
      next_test_two_internal = retain_sync ? `RFSC_TEST_TWO_RETAIN : `RFSC_RST_TEST_TWO;
    end
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // unmapped addresses and unused bits read zero
  always_comb begin
    next_rdata = 8'h00;
    if (reg_read_in) begin
      unique case (reg_addr_in)
        `RFSC_ADDR_TX_FRONT_END: next_rdata = tx_front_end_cfg;
        `RFSC_ADDR_CHARGE_PUMP: next_rdata = charge_pump_cal_reg;
        `RFSC_ADDR_VCO_CURRENT: next_rdata = vco_current_cal_reg;
        `RFSC_ADDR_VCO_COARSE: next_rdata = vco_coarse_cap_reg;
        `RFSC_ADDR_SYNTH_CTRL: next_rdata = synth_cal_control_reg;
        `RFSC_ADDR_VOL_A: next_rdata = vol_a;
        `RFSC_ADDR_VOL_B: next_rdata = vol_b;
        `RFSC_ADDR_VOL_C: next_rdata = vol_c;
        `RFSC_ADDR_TEST_TWO: next_rdata = test_two;
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      tx_front_end_cfg <= `RFSC_RST_TX_FRONT_END;
      charge_pump_cal_reg <= `RFSC_RST_CHARGE_PUMP;
      vco_current_cal_reg <= `RFSC_RST_VCO_CURRENT;
      vco_coarse_cap_reg <= `RFSC_RST_VCO_COARSE;
      synth_cal_control_reg <= `RFSC_RST_SYNTH_CTRL;
      vol_a <= `RFSC_RST_VOL_A;
      vol_b <= `RFSC_RST_VOL_B;
      vol_c <= `RFSC_RST_VOL_C;
      test_two <= `RFSC_RST_TEST_TWO;
      test_two_internal <= `RFSC_RST_TEST_TWO;
      reg_rdata_out <= 8'h00;
      tx_lo_buffer_current_out <= 2'b00;
      vco_core_high_select_out <= 1'b0;
      charge_pump_current_out <= 4'h0;
      vco_current_out <= 5'h00;
      vco_coarse_out <= 6'h00;
      synth_cal_control_out <= 7'h00;
      synth_cal_config_out <= 2'b00;
      analog_test_word_out <= 8'h00;
      cal_busy_out <= 1'b0;
    end else begin
      tx_front_end_cfg <= next_tx_front_end_cfg;
      charge_pump_cal_reg <= next_charge_pump_cal_reg;
      vco_current_cal_reg <= next_vco_current_cal_reg;
      vco_coarse_cap_reg <= next_vco_coarse_cap_reg;
      synth_cal_control_reg <= next_synth_cal_control_reg;
      vol_a <= next_vol_a;
      vol_b <= next_vol_b;
      vol_c <= next_vol_c;
      test_two <= next_test_two;
      test_two_internal <= next_test_two_internal;
      reg_rdata_out <= next_rdata;
      tx_lo_buffer_current_out <= tx_front_end_cfg[`RFSC_LO_CUR_MSB:`RFSC_LO_CUR_LSB];
      vco_core_high_select_out <= vco_current_cal_reg[`RFSC_VCO_HIGH_BIT];
      charge_pump_current_out <= charge_pump_cal_reg[`RFSC_CP_RES_MSB:0];
      vco_current_out <= vco_current_cal_reg[`RFSC_VCO_CUR_MSB:0];
      vco_coarse_out <= vco_coarse_cap_reg[`RFSC_COARSE_MSB:0];
      synth_cal_control_out <= synth_cal_control_reg[`RFSC_CTRL_MSB:0];
      synth_cal_config_out <= charge_pump_cal_reg[`RFSC_CAL_CFG_MSB:`RFSC_CAL_CFG_LSB];
      analog_test_word_out <= test_two_internal;
      cal_busy_out <= (next_cal_state != RFSC_CAL_IDLE);
    end
  end

  // ----------------------------------------
  // power table
  // ----------------------------------------
  rfsc_power_table #(.ENTRIES(TABLE_ENTRIES)) u_table (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .write_in(table_write_in),
    .write_index_in(table_index_in),
    .write_data_in(table_data_in),
    .level_index_in(tx_front_end_cfg[`RFSC_AMP_IDX_MSB:0]),
    .amp_setting_out(amp_setting_out)
  );

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence s_cal_start_no_cp;
    cal_state == RFSC_CAL_IDLE && cal_start_in && !sleep_sync &&
      charge_pump_cal_reg[`RFSC_CP_EN_MSB:`RFSC_CP_EN_LSB] == 2'b00;
  endsequence

  a_cp_stage_skip: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    s_cal_start_no_cp |=> cal_state == RFSC_CAL_VCO_CURRENT)
    else $error("charge-pump stage not skipped");

  a_wake_test_read: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    wake_event ##1 (reg_read_in && reg_addr_in == `RFSC_ADDR_TEST_TWO && !reg_write_in)
      |=> reg_rdata_out == `RFSC_RST_TEST_TWO)
    else $error("test word read after wake not reset value");

  a_wake_internal: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    wake_event && !reg_write_in |=> ##1
      analog_test_word_out == ($past(retain_sync, 2) ? `RFSC_TEST_TWO_RETAIN : `RFSC_RST_TEST_TWO))
    else $error("internal test word wrong after wake");

  a_sleep_volatile: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    sleep_sync [*2] |-> vol_a == `RFSC_RST_VOL_A && vol_b == `RFSC_RST_VOL_B && vol_c == `RFSC_RST_VOL_C)
    else $error("volatile register kept during sleep");

  a_unused_zero: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    reg_read_in && reg_addr_in == `RFSC_ADDR_TX_FRONT_END |=> (reg_rdata_out & ~`RFSC_MASK_TX_FRONT_END) == 8'h00)
    else $error("unused bits not zero");

  a_vco_core_sel: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    ##1 vco_core_high_select_out == $past(vco_current_cal_reg[`RFSC_VCO_HIGH_BIT]))
    else $error("vco core select does not follow register");

  a_vco_override: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    reg_write_in && reg_addr_in == `RFSC_ADDR_VCO_CURRENT
      |=> ##1 vco_current_out == $past(reg_wdata_in[`RFSC_VCO_CUR_MSB:0], 2))
    else $error("vco current override lost");

  a_coarse_capture: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cal_state == RFSC_CAL_COARSE && stage_count == `RFSC_STAGE_CYCLES - 5'h01 && !reg_write_in
      |=> vco_coarse_cap_reg[`RFSC_COARSE_MSB:0] == $past(coarse_result_in) ##1 cal_state == RFSC_CAL_IDLE)
    else $error("coarse result not captured");

  a_cp_capture: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    cal_state == RFSC_CAL_CHARGE_PUMP && stage_count == `RFSC_STAGE_CYCLES - 5'h01 && !reg_write_in
      |=> charge_pump_cal_reg[`RFSC_CP_RES_MSB:0] == $past(cp_result_in))
    else $error("charge-pump result not captured");

  a_ctrl_width: assert property (@(posedge clock_in) disable iff (!reset_n_in)
    (synth_cal_control_reg & ~`RFSC_MASK_SYNTH_CTRL) == 8'h00)
    else $error("unused control bit set");
endmodule

// ==== tb/rfsc_host_model.sv ====
// host-side model that drives the register port of the bank
`timescale 1ns/100ps
`include "rfsc_consts.svh"
module rfsc_host_model (
  input wire logic clock_in,
  input wire logic [7:0] reg_rdata_in,
  output logic reg_write_out,
  output logic reg_read_out,
  output logic [5:0] reg_addr_out,
  output logic [7:0] reg_wdata_out
);
  // ----------------------------------------
  // register port cycles
  // ----------------------------------------
  // idle bus at time zero
  initial begin
    reg_write_out = 1'b0;
    reg_read_out = 1'b0;
    reg_addr_out = 6'h00;
    reg_wdata_out = 8'h00;
  end

  // one-cycle write strobe; released lines show inverted junk, not stale data
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge clock_in);
    reg_write_out <= 1'b1;
    reg_addr_out <= a;
    reg_wdata_out <= d;
    @(posedge clock_in);
    reg_write_out <= 1'b0;
    reg_addr_out <= ~a;
    reg_wdata_out <= ~d;
  endtask

  // read data lands at the taking edge and stands one cycle
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(posedge clock_in);
    reg_read_out <= 1'b1;
    reg_addr_out <= a;
    @(posedge clock_in);
    reg_read_out <= 1'b0;
    reg_addr_out <= ~a;
    #1 d = reg_rdata_in;
  endtask

  // amplifier level: 001 for on-off keying, 000 for the other formats
  task automatic set_level(input logic ook, input logic [1:0] lo_cur);
    wr(`RFSC_ADDR_TX_FRONT_END, {2'b00, lo_cur, 1'b0, (ook ? 3'b001 : 3'b000)});
  endtask

  // configuration bits 7:6 go in before any calibration is started
  task automatic cal_prepare(input logic [1:0] cfg, input logic [1:0] en, input logic [3:0] res);
    wr(`RFSC_ADDR_CHARGE_PUMP, {cfg, en, res});
  endtask
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the front-end and synthesizer register bank
`timescale 1ns/100ps
`include "rfsc_consts.svh"
module tb_top;
  logic clock_in, reset_n_in, table_write_in, sleep_in, converter_retention_select_in, cal_start_in;
  logic [2:0] table_index_in;
  logic [7:0] table_data_in, reg_rdata_out, amp_setting_out, analog_test_word_out, rv, wdata;
  logic [3:0] cp_result_in, charge_pump_current_out;
  logic [4:0] vco_current_result_in, vco_current_out;
  logic [5:0] coarse_result_in, vco_coarse_out, addr;
  logic [1:0] tx_lo_buffer_current_out, synth_cal_config_out;
  logic [6:0] synth_cal_control_out;
  logic vco_core_high_select_out, cal_busy_out, wr_s, rd_s;
  int num_errors = 0;
  int num_checks = 0;

  rfsc_host_model host_i (.clock_in(clock_in), .reg_rdata_in(reg_rdata_out), .reg_write_out(wr_s),
    .reg_read_out(rd_s), .reg_addr_out(addr), .reg_wdata_out(wdata));
  rfsc_regs #(.TABLE_ENTRIES(2)) rfsc_regs_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
    .reg_write_in(wr_s), .reg_read_in(rd_s), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .table_write_in(table_write_in), .table_index_in(table_index_in), .table_data_in(table_data_in),
    .sleep_in(sleep_in), .converter_retention_select_in(converter_retention_select_in),
    .cal_start_in(cal_start_in), .cp_result_in(cp_result_in), .vco_current_result_in(vco_current_result_in),
    .coarse_result_in(coarse_result_in), .reg_rdata_out(reg_rdata_out), .amp_setting_out(amp_setting_out),
    .tx_lo_buffer_current_out(tx_lo_buffer_current_out), .vco_core_high_select_out(vco_core_high_select_out),
    .charge_pump_current_out(charge_pump_current_out), .vco_current_out(vco_current_out),
    .vco_coarse_out(vco_coarse_out), .synth_cal_control_out(synth_cal_control_out),
    .synth_cal_config_out(synth_cal_config_out), .analog_test_word_out(analog_test_word_out),
    .cal_busy_out(cal_busy_out));

  // ----------------------------------------
  // clock, checking and closing
  // ----------------------------------------
  // 125 MHz clock
  initial begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // read one register and compare
  task automatic rchk(input logic [5:0] a, input logic [7:0] exp);
    host_i.rd(a, rv);
    check($sformatf("reg %h", a), rv, exp);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // every mapped register at reset, plus two unmapped places
  task automatic t_reset_values();
    rchk(`RFSC_ADDR_TX_FRONT_END, `RFSC_RST_TX_FRONT_END);
    rchk(`RFSC_ADDR_CHARGE_PUMP, 8'ha9);
    rchk(`RFSC_ADDR_VCO_CURRENT, 8'h0a);
    rchk(`RFSC_ADDR_VCO_COARSE, 8'h20);
    rchk(`RFSC_ADDR_SYNTH_CTRL, 8'h0d);
    rchk(`RFSC_ADDR_VOL_A, 8'h59);
    rchk(`RFSC_ADDR_VOL_B, 8'h7f);
    rchk(`RFSC_ADDR_VOL_C, 8'h3f);
    rchk(`RFSC_ADDR_TEST_TWO, 8'h88);
    rchk(6'h27, 8'h00);
    rchk(6'h00, 8'h00);
  endtask

  // all ones to the five front-end/synth registers and one unmapped place: unused bits must stay zero, fields reach their outputs
  task automatic t_masks();
    logic [5:0] a_list [5] = '{6'h22, 6'h23, 6'h24, 6'h25, 6'h26};
    logic [7:0] m_list [5] = '{8'h37, 8'hff, 8'h3f, 8'h3f, 8'h7f};
    for (int i = 0; i < 5; i++) host_i.wr(a_list[i], 8'hff);
    host_i.wr(6'h27, 8'hff);
    for (int i = 0; i < 5; i++) rchk(a_list[i], m_list[i]);
    rchk(6'h27, 8'h00);
    check("core high", {7'h0, vco_core_high_select_out}, 8'h01);
    check("vco current", {3'h0, vco_current_out}, 8'h1f);
    check("coarse", {2'h0, vco_coarse_out}, 8'h3f);
    check("cal control", {1'h0, synth_cal_control_out}, 8'h7f);
    check("cp current", {4'h0, charge_pump_current_out}, 8'h0f);
    check("cal config", {6'h0, synth_cal_config_out}, 8'h03);
    check("lo current", {6'h0, tx_lo_buffer_current_out}, 8'h03);
    host_i.wr(`RFSC_ADDR_VCO_CURRENT, 8'h0a);
    host_i.wr(`RFSC_ADDR_SYNTH_CTRL, 8'h0d);
    repeat (2) @(posedge clock_in);
    check("core low", {7'h0, vco_core_high_select_out}, 8'h00);
    check("cal control back", {1'h0, synth_cal_control_out}, 8'h0d);
  endtask

  // two table entries; an index past the end folds onto the last entry
  task automatic t_power_table();
    logic [7:0] d [2] = '{8'h12, 8'hc5};
    for (int i = 0; i < 2; i++) begin
      @(posedge clock_in);
      table_write_in <= 1'b1;
      table_index_in <= i[2:0];
      table_data_in <= d[i];
    end
    @(posedge clock_in);
    table_write_in <= 1'b0;
    table_data_in <= 8'h00;
    host_i.set_level(1'b0, 2'b01);
    repeat (3) @(posedge clock_in);
    check("amp idx0", amp_setting_out, 8'h12);
    host_i.set_level(1'b1, 2'b10);
    repeat (3) @(posedge clock_in);
    check("amp idx1", amp_setting_out, 8'hc5);
    check("lo current", {6'h0, tx_lo_buffer_current_out}, 8'h02);
    host_i.wr(`RFSC_ADDR_TX_FRONT_END, 8'h17);
    repeat (3) @(posedge clock_in);
    check("amp idx7", amp_setting_out, 8'hc5);
  endtask

  // one calibration run; the charge-pump stage runs only when enabled
  task automatic t_cal(input logic [1:0] en, input int exp_busy);
    int n;
    n = 0;
    host_i.cal_prepare(2'b10, en, 4'h5);
    cp_result_in <= 4'hc;
    vco_current_result_in <= 5'h13;
    coarse_result_in <= 6'h2d;
    @(posedge clock_in);
    cal_start_in <= 1'b1;
    @(posedge clock_in);
    cal_start_in <= 1'b0;
    // look a step after each edge so the registered busy flag is counted once per cycle
    #1;
    while (cal_busy_out === 1'b1 && n < 200) begin
      n++;
      @(posedge clock_in);
      #1;
    end
    check("busy cycles", n[7:0], exp_busy[7:0]);
    rchk(`RFSC_ADDR_CHARGE_PUMP, {2'b10, en, ((en != 2'b00) ? 4'hc : 4'h5)});
    rchk(`RFSC_ADDR_VCO_CURRENT, 8'h13);
    rchk(`RFSC_ADDR_VCO_COARSE, 8'h2d);
    check("cp out", {4'h0, charge_pump_current_out}, (en != 2'b00) ? 8'h0c : 8'h05);
    host_i.wr(`RFSC_ADDR_VCO_CURRENT, 8'h07);
    rchk(`RFSC_ADDR_VCO_CURRENT, 8'h07);
  endtask

  // sleep wipes the volatile group; a write while asleep does not stick
  task automatic t_sleep(input logic keep);
    for (int i = 0; i < 4; i++) host_i.wr(6'h29 + i[5:0], 8'h00);
    converter_retention_select_in <= keep;
    sleep_in <= 1'b1;
    repeat (6) @(posedge clock_in);
    host_i.wr(`RFSC_ADDR_VOL_A, 8'h00);
    sleep_in <= 1'b0;
    // the read strobe lands in the cycle right after the synchronised wake edge
    repeat (2) @(posedge clock_in);
    rchk(`RFSC_ADDR_TEST_TWO, 8'h88);
    check("test word", analog_test_word_out, keep ? `RFSC_TEST_TWO_RETAIN : 8'h88);
    rchk(`RFSC_ADDR_VOL_A, 8'h59);
    rchk(`RFSC_ADDR_VOL_B, 8'h7f);
    rchk(`RFSC_ADDR_VOL_C, 8'h3f);
  endtask

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  // inputs at time zero, reset for eight cycles, then the scenarios
  initial begin
    reset_n_in = 1'b0;
    table_write_in = 1'b0;
    table_index_in = 3'h0;
    table_data_in = 8'h00;
    sleep_in = 1'b0;
    converter_retention_select_in = 1'b0;
    cal_start_in = 1'b0;
    cp_result_in = 4'h0;
    vco_current_result_in = 5'h00;
    coarse_result_in = 6'h00;
    repeat (8) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    t_masks();
    t_power_table();
    t_cal(2'b10, 49);
    t_cal(2'b00, 33);
    t_sleep(1'b0);
    t_sleep(1'b1);
    conclude();
  end

  // the scenarios need well under two thousand cycles
  initial begin
    repeat (20000) @(posedge clock_in);
    num_errors++;
    conclude();
  end
endmodule
